// File: verilog/sbst_pkg.sv
// Shared constants, codes and types of the boundary scan test port and its controller
package sbst_pkg;

   // Register widths
   localparam int SBST_IR_W = 3;
   localparam int SBST_ID_W = 32;
   localparam int SBST_BSR_W = 16;
   localparam int SBST_FLOAT_BIT = 15;

   // Identification code, value arbitrary
   localparam logic [SBST_ID_W-1:0] SBST_ID_CODE = 32'h0a5c_3001;

   // Instruction codes
   localparam logic [SBST_IR_W-1:0] SBST_IR_EXTEST = 3'h0;
   localparam logic [SBST_IR_W-1:0] SBST_IR_IDCODE = 3'h1;
   localparam logic [SBST_IR_W-1:0] SBST_IR_SAMPLEZ = 3'h2;
   localparam logic [SBST_IR_W-1:0] SBST_IR_SAMPLE = 3'h4;
   localparam logic [SBST_IR_W-1:0] SBST_IR_BYPASS = 3'h7;
   // Pattern loaded by Capture-IR, low bits 01
   localparam logic [SBST_IR_W-1:0] SBST_IR_CAPTURE = 3'h1;

   // Data register selection
   localparam logic [1:0] SBST_SEL_BYP = 2'h0;
   localparam logic [1:0] SBST_SEL_ID = 2'h1;
   localparam logic [1:0] SBST_SEL_BS = 2'h2;

   // Controller commands and their TMS headers, sent LSB first
   localparam logic [1:0] SBST_CMD_RST = 2'h0;
   localparam logic [1:0] SBST_CMD_IR = 2'h1;
   localparam logic [1:0] SBST_CMD_DR = 2'h2;
   localparam int SBST_HEAD_W = 6;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_RST = 6'h1f;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_IR = 6'h03;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_DR = 6'h01;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_RST_N = 6'h06;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_IR_N = 6'h04;
   localparam logic [SBST_HEAD_W-1:0] SBST_HEAD_DR_N = 6'h03;
   localparam logic [SBST_HEAD_W-1:0] SBST_TAIL_N = 6'h02;

   // Test clock half period in system clocks
   localparam int SBST_HALF_CYC = 8;

   typedef enum logic [15:0] {
      SBST_TLR = 16'h0001,
      SBST_RTI = 16'h0002,
      SBST_SEL_DR = 16'h0004,
      SBST_CAP_DR = 16'h0008,
      SBST_SHF_DR = 16'h0010,
      SBST_EX1_DR = 16'h0020,
      SBST_PAU_DR = 16'h0040,
      SBST_EX2_DR = 16'h0080,
      SBST_UPD_DR = 16'h0100,
      SBST_SEL_IR = 16'h0200,
      SBST_CAP_IR = 16'h0400,
      SBST_SHF_IR = 16'h0800,
      SBST_EX1_IR = 16'h1000,
      SBST_PAU_IR = 16'h2000,
      SBST_EX2_IR = 16'h4000,
      SBST_UPD_IR = 16'h8000
   } sbst_tap_e;

   typedef enum logic [4:0] {
      SBST_H_IDLE = 5'h01,
      SBST_H_HEAD = 5'h02,
      SBST_H_SHIFT = 5'h04,
      SBST_H_TAIL = 5'h08,
      SBST_H_DONE = 5'h10
   } sbst_hph_e;

   // Reserved codes fall back to the bypass register
   function automatic logic [1:0] sbst_dr_sel(input logic [SBST_IR_W-1:0] ir);
      case (ir)
         SBST_IR_IDCODE: sbst_dr_sel = SBST_SEL_ID;
         SBST_IR_EXTEST, SBST_IR_SAMPLE, SBST_IR_SAMPLEZ: sbst_dr_sel = SBST_SEL_BS;
         default: sbst_dr_sel = SBST_SEL_BYP;
      endcase
   endfunction : sbst_dr_sel

endpackage : sbst_pkg

// File: verilog/sbst_jtag_if.sv
// Test port wires between the memory test port and its external controller
`timescale 1ns/1ps
interface sbst_jtag_if;
   logic tck;
   logic tms_drv;
   logic tms_oe;
   logic tdi_drv;
   logic tdi_oe;
   logic tdo_drv;
   logic tdo_oe;
   logic tms;
   logic tdi;
   logic tdo;

   // Internal pull-ups make undriven select and data inputs read high
   assign tms = tms_oe ? tms_drv : 1'b1;
   assign tdi = tdi_oe ? tdi_drv : 1'b1;
   // Floating data out is seen as high by the controller
   assign tdo = tdo_oe ? tdo_drv : 1'b1;

   modport dev (
      input tck,
      input tms,
      input tdi,
      output tdo_drv,
      output tdo_oe
   );

   modport host (
      output tck,
      output tms_drv,
      output tms_oe,
      output tdi_drv,
      output tdi_oe,
      input tdo
   );
endinterface : sbst_jtag_if

// File: verilog/sbst_tap_dev.sv
// Boundary scan test port of the memory: controller, instruction and data registers
`timescale 1ns/1ps
// Operation
// - Sample on test clock rise, drive on fall
// - State steps follow TMS at clock rise
// - TDI and TMS read high when open
// - Unused port needs test clock held low
// - TDI into MSB, TDO from LSB
// - TDO drives only in shift states
// - Five TMS-high rises reset the controller
// - Power-up reset floats TDO
// - Exactly one data register in path
// - Three-bit instruction register, shifted in serially
// - Identification instruction after power-up and reset
// - Capture-IR loads 01 into low bits
// - One-bit bypass, cleared on capture
// - Boundary cell for every input pin
// - Boundary register captures ring, shifts in path
// - Identification capture loads fixed 32-bit code
// - Eight codes, three reserved and unused
// - New instruction acts at Update-IR only
// - EXTEST drives preloaded cells onto pins
// - Sample-and-float floats all memory outputs
// - Bypass instruction puts bypass in path
// - Float cell gates bus, preset high
module sbst_tap_dev
   import sbst_pkg::*;
#(
   parameter int BSR_W = SBST_BSR_W,
   parameter int FLOAT_BIT = SBST_FLOAT_BIT,
   parameter logic [SBST_ID_W-1:0] ID_CODE = SBST_ID_CODE
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Test port pins
   sbst_jtag_if.dev jtag,
   // Memory pin ring
   input wire logic [BSR_W-1:0] pin_in_i,
   output logic pin_test_o,
   output logic [BSR_W-1:0] pin_val_o,
   output logic q_float_o
);

   typedef struct packed {
      logic tck_s1;
      logic tck_s2;
      logic tck_d;
      logic tms_s1;
      logic tms_s2;
      logic tdi_s1;
      logic tdi_s2;
      logic [BSR_W-1:0] pin_s1;
      logic [BSR_W-1:0] pin_s2;
      sbst_tap_e st;
      logic [SBST_IR_W-1:0] ir;
      logic [SBST_IR_W-1:0] ir_sr;
      logic byp;
      logic [SBST_ID_W-1:0] id_sr;
      logic [BSR_W-1:0] bs_sr;
      logic [BSR_W-1:0] upd;
      logic tdo;
      logic tdo_oe;
      logic pin_test;
      logic q_float;
   } sbst_dev_s;

   localparam logic [BSR_W-1:0] UPD_RST = BSR_W'(1) << FLOAT_BIT;
   localparam sbst_dev_s DEV_RST = '{
      tms_s1: 1'b1,
      tms_s2: 1'b1,
      tdi_s1: 1'b1,
      tdi_s2: 1'b1,
      st: SBST_TLR,
      ir: SBST_IR_IDCODE,
      upd: UPD_RST,
      default: '0
   };

   sbst_dev_s r;
   sbst_dev_s next_r;
   logic rise;
   logic fall;
   logic [1:0] sel;
   logic dr_lsb;

   function automatic sbst_tap_e sbst_next_tap(input sbst_tap_e s, input logic tms);
      case (s)
         SBST_TLR: sbst_next_tap = tms ? SBST_TLR : SBST_RTI;
         SBST_RTI: sbst_next_tap = tms ? SBST_SEL_DR : SBST_RTI;
         SBST_SEL_DR: sbst_next_tap = tms ? SBST_SEL_IR : SBST_CAP_DR;
         SBST_CAP_DR: sbst_next_tap = tms ? SBST_EX1_DR : SBST_SHF_DR;
         SBST_SHF_DR: sbst_next_tap = tms ? SBST_EX1_DR : SBST_SHF_DR;
         SBST_EX1_DR: sbst_next_tap = tms ? SBST_UPD_DR : SBST_PAU_DR;
         SBST_PAU_DR: sbst_next_tap = tms ? SBST_EX2_DR : SBST_PAU_DR;
         SBST_EX2_DR: sbst_next_tap = tms ? SBST_UPD_DR : SBST_SHF_DR;
         SBST_UPD_DR: sbst_next_tap = tms ? SBST_SEL_DR : SBST_RTI;
         // TMS high from any state reaches reset within five rises
         SBST_SEL_IR: sbst_next_tap = tms ? SBST_TLR : SBST_CAP_IR;
         SBST_CAP_IR: sbst_next_tap = tms ? SBST_EX1_IR : SBST_SHF_IR;
         SBST_SHF_IR: sbst_next_tap = tms ? SBST_EX1_IR : SBST_SHF_IR;
         SBST_EX1_IR: sbst_next_tap = tms ? SBST_UPD_IR : SBST_PAU_IR;
         SBST_PAU_IR: sbst_next_tap = tms ? SBST_EX2_IR : SBST_PAU_IR;
         SBST_EX2_IR: sbst_next_tap = tms ? SBST_UPD_IR : SBST_SHF_IR;
         SBST_UPD_IR: sbst_next_tap = tms ? SBST_SEL_DR : SBST_RTI;
         default: sbst_next_tap = SBST_TLR;
      endcase
   endfunction : sbst_next_tap

   always_comb
   begin
      next_r = r;
      // pins synchronised, TMS and TDI reset to the pulled-up level, test clock to low
      next_r.tck_s1 = jtag.tck;
      next_r.tck_s2 = r.tck_s1;
      next_r.tck_d = r.tck_s2;
      next_r.tms_s1 = jtag.tms;
      next_r.tms_s2 = r.tms_s1;
      next_r.tdi_s1 = jtag.tdi;
      next_r.tdi_s2 = r.tdi_s1;
      // every ring pin has a cell
      next_r.pin_s1 = pin_in_i;
      next_r.pin_s2 = r.pin_s1;
      // edges found on the synchronised test clock
      rise = r.tck_s2 & ~r.tck_d;
      fall = ~r.tck_s2 & r.tck_d;
      // one data register chosen by the instruction
      sel = sbst_dr_sel(r.ir);
      // data out taken from the LSB
      case (sel)
         SBST_SEL_ID: dr_lsb = r.id_sr[0];
         SBST_SEL_BS: dr_lsb = r.bs_sr[0];
         default: dr_lsb = r.byp;
      endcase
      if (rise)
      begin
         next_r.st = sbst_next_tap(r.st, r.tms_s2);
         case (r.st)
            SBST_CAP_IR: next_r.ir_sr = SBST_IR_CAPTURE;
            SBST_SHF_IR: next_r.ir_sr = {r.tdi_s2, r.ir_sr[SBST_IR_W-1:1]};
            SBST_CAP_DR:
            begin
               case (sel)
                  SBST_SEL_ID: next_r.id_sr = ID_CODE;
                  SBST_SEL_BS: next_r.bs_sr = r.pin_s2;
                  default: next_r.byp = 1'b0;
               endcase
            end
            SBST_SHF_DR:
            begin
               case (sel)
                  SBST_SEL_ID: next_r.id_sr = {r.tdi_s2, r.id_sr[SBST_ID_W-1:1]};
                  SBST_SEL_BS: next_r.bs_sr = {r.tdi_s2, r.bs_sr[BSR_W-1:1]};
                  default: next_r.byp = r.tdi_s2;
               endcase
            end
            default: ;
         endcase
      end
      if (fall)
      begin
         next_r.tdo_oe = (r.st == SBST_SHF_IR) || (r.st == SBST_SHF_DR);
         next_r.tdo = (r.st == SBST_SHF_IR) ? r.ir_sr[0] : dr_lsb;
         if (r.st == SBST_UPD_IR)
         begin
            next_r.ir = r.ir_sr;
         end
         if ((r.st == SBST_UPD_DR) && (sel == SBST_SEL_BS))
         begin
            next_r.upd = r.bs_sr;
         end
      end
      // reset state forces identification and presets float cell
      if (r.st == SBST_TLR)
      begin
         next_r.ir = SBST_IR_IDCODE;
         next_r.upd[FLOAT_BIT] = 1'b1;
      end
      // pins take preloaded cells under EXTEST
      next_r.pin_test = (r.ir == SBST_IR_EXTEST);
      // float cell gates the bus; sample-and-float floats all
      next_r.q_float = (r.ir == SBST_IR_SAMPLEZ) ||
                       ((r.ir == SBST_IR_EXTEST) && !r.upd[FLOAT_BIT]);
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r <= DEV_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign jtag.tdo_drv = r.tdo;
   assign jtag.tdo_oe = r.tdo_oe;
   assign pin_test_o = r.pin_test;
   assign pin_val_o = r.upd;
   assign q_float_o = r.q_float;

endmodule : sbst_tap_dev

// File: verilog/sbst_tap_host.sv
// External test controller that clocks the test port and runs reset, IR and DR scans
`timescale 1ns/1ps
module sbst_tap_host
   import sbst_pkg::*;
#(
   parameter int DATA_W = SBST_ID_W,
   parameter int HALF_CYC = SBST_HALF_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Test port pins
   sbst_jtag_if.host jtag,
   // Command side
   input wire logic cmd_valid_i,
   input wire logic [1:0] cmd_i,
   input wire logic [SBST_HEAD_W-1:0] len_i,
   input wire logic [DATA_W-1:0] data_i,
   output logic cmd_ready_o,
   // Answer side
   output logic rsp_valid_o,
   output logic [DATA_W-1:0] rsp_data_o
);

   typedef struct packed {
      sbst_hph_e ph;
      logic [7:0] div;
      logic tck;
      logic tms;
      logic tdi;
      logic drv;
      logic [1:0] cmd;
      logic [SBST_HEAD_W-1:0] cnt;
      logic [SBST_HEAD_W-1:0] pat;
      logic [SBST_HEAD_W-1:0] len;
      logic [DATA_W-1:0] tx;
      logic [DATA_W-1:0] rx;
      logic tdo_s1;
      logic tdo_s2;
      logic ready;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
   } sbst_host_s;

   // test clock parked low, so an idle port never leaves its state
   localparam sbst_host_s HOST_RST = '{
      ph: SBST_H_IDLE,
      tms: 1'b1,
      tdi: 1'b1,
      drv: 1'b1,
      ready: 1'b1,
      default: '0
   };
   localparam logic [7:0] DIV_END = 8'(HALF_CYC - 1);

   sbst_host_s r;
   sbst_host_s next_r;

   always_comb
   begin
      next_r = r;
      next_r.tdo_s1 = jtag.tdo;
      next_r.tdo_s2 = r.tdo_s1;
      next_r.rsp_valid = 1'b0;
      case (r.ph)
         SBST_H_IDLE:
         begin
            if (cmd_valid_i)
            begin
               next_r.ready = 1'b0;
               next_r.cmd = cmd_i;
               next_r.len = len_i;
               next_r.tx = data_i;
               next_r.div = '0;
               next_r.ph = SBST_H_HEAD;
               case (cmd_i)
                  SBST_CMD_IR:
                  begin
                     next_r.pat = SBST_HEAD_IR;
                     next_r.cnt = SBST_HEAD_IR_N;
                  end
                  SBST_CMD_DR:
                  begin
                     next_r.pat = SBST_HEAD_DR;
                     next_r.cnt = SBST_HEAD_DR_N;
                  end
                  default:
                  begin
                     // five TMS-high rises, then one low into idle
                     next_r.pat = SBST_HEAD_RST;
                     next_r.cnt = SBST_HEAD_RST_N;
                  end
               endcase
               next_r.tms = next_r.pat[0];
            end
         end
         SBST_H_DONE:
         begin
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = r.rx >> (SBST_HEAD_W'(DATA_W) - r.len);
            next_r.ready = 1'b1;
            next_r.ph = SBST_H_IDLE;
         end
         default:
         begin
            if (r.div == DIV_END)
            begin
               next_r.div = '0;
               next_r.tck = ~r.tck;
               if (!r.tck)
               begin
                  if (r.ph == SBST_H_SHIFT)
                  begin
                     next_r.rx = {r.tdo_s2, r.rx[DATA_W-1:1]};
                  end
               end
               else
               begin
                  // Pins change on the falling edge, well clear of the rise
                  case (r.ph)
                     SBST_H_HEAD:
                     begin
                        if (r.cnt > SBST_HEAD_W'(1))
                        begin
                           next_r.pat = r.pat >> 1;
                           next_r.cnt = r.cnt - SBST_HEAD_W'(1);
                           next_r.tms = r.pat[1];
                        end
                        else if (r.cmd == SBST_CMD_RST || r.cmd == 2'h3)
                        begin
                           next_r.ph = SBST_H_DONE;
                        end
                        else
                        begin
                           next_r.ph = SBST_H_SHIFT;
                           next_r.cnt = r.len;
                           next_r.tms = (r.len == SBST_HEAD_W'(1));
                           next_r.tdi = r.tx[0];
                        end
                     end
                     SBST_H_SHIFT:
                     begin
                        if (r.cnt > SBST_HEAD_W'(1))
                        begin
                           next_r.tx = r.tx >> 1;
                           next_r.cnt = r.cnt - SBST_HEAD_W'(1);
                           next_r.tdi = r.tx[1];
                           next_r.tms = (r.cnt == SBST_HEAD_W'(2));
                        end
                        else
                        begin
                           // pass Update so the new value takes effect
                           next_r.ph = SBST_H_TAIL;
                           next_r.cnt = SBST_TAIL_N;
                           next_r.tms = 1'b1;
                        end
                     end
                     SBST_H_TAIL:
                     begin
                        if (r.cnt == SBST_TAIL_N)
                        begin
                           next_r.cnt = SBST_HEAD_W'(1);
                           next_r.tms = 1'b0;
                        end
                        else
                        begin
                           next_r.ph = SBST_H_DONE;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            else
            begin
               next_r.div = r.div + 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r <= HOST_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign jtag.tck = r.tck;
   assign jtag.tms_drv = r.tms;
   assign jtag.tms_oe = r.drv;
   assign jtag.tdi_drv = r.tdi;
   assign jtag.tdi_oe = r.drv;
   assign cmd_ready_o = r.ready;
   assign rsp_valid_o = r.rsp_valid;
   assign rsp_data_o = r.rsp_data;

endmodule : sbst_tap_host

// File: bench/sbst_tap_monitor.sv
// Checks on the wires between the test controller and the test port
`timescale 1ns/1ps
module sbst_tap_monitor
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Test port wires
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo_drv,
   input wire logic tdo_oe,
   input wire logic tdo
);
   logic tck_q;
   logic [2:0] hi_cnt;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // Run of TMS-high rises; saturates so it never wraps back to zero
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tck_q <= 1'b0;
         hi_cnt <= 3'h0;
      end
      else
      begin
         tck_q <= tck;
         if (tck && !tck_q)
         begin
            hi_cnt <= !tms ? 3'h0 : hi_cnt + {2'h0, hi_cnt != 3'h7};
         end
      end
   end
   sequence s_rise_hi;
      $rose(tck) && tms;
   endsequence
   sequence s_out_move;
      $changed(tdo_drv) || $changed(tdo_oe);
   endsequence
   tms_steady_a: assert property ($changed(tms) |-> !tck)
      else $error("TMS moved while test clock high");
   tdi_steady_a: assert property ($changed(tdi) |-> !tck)
      else $error("TDI moved while test clock high");
   out_fall_a: assert property (s_out_move |-> !tck && !$past(tck, 2))
      else $error("TDO moved away from a falling edge");
   out_hold_a: assert property ($fell(tck) |=> $stable(tdo_drv) [*2])
      else $error("TDO moved too early after a fall");
   oe_rise_a: assert property ($rose(tdo_oe) |-> !$past(tms, 12))
      else $error("TDO enabled without a TMS-low step");
   oe_fall_a: assert property ($fell(tdo_oe) |-> $past(tms, 12))
      else $error("TDO released without a TMS-high step");
   exit_float_a: assert property (s_rise_hi |-> ##13 !tdo_oe)
      else $error("TDO driven after a TMS-high step");
   reset_run_a: assert property (hi_cnt >= 3'h5 |-> !tdo_oe && tdo)
      else $error("TDO driven after five TMS-high rises");
   power_float_a: assert property ($rose(nrst_i) |-> !tdo_oe)
      else $error("TDO driven after power-up");
endmodule : sbst_tap_monitor

// File: bench/sram_boundary_scan_tap_tb.sv
// Bench joining controller and test port, answers compared with a model
`timescale 1ns/1ps
module sram_boundary_scan_tap_tb;
   import sbst_pkg::*;
   logic clk_i;
   logic nrst_i;
   logic [SBST_BSR_W-1:0] pin_in_i;
   logic pin_test_o;
   logic [SBST_BSR_W-1:0] pin_val_o;
   logic q_float_o;
   logic cmd_valid_i;
   logic [1:0] cmd_i;
   logic [SBST_HEAD_W-1:0] len_i;
   logic [SBST_ID_W-1:0] data_i;
   logic cmd_ready_o;
   logic rsp_valid_o;
   logic [SBST_ID_W-1:0] rsp_data_o;
   logic [31:0] wire_bits;
   integer err_count;
   integer checks;
   integer cycles;
   integer seed;
   integer m_ir;
   integer m_pv;
   integer exp_q[$];
   integer i;

   sbst_jtag_if sbst_jtag_if_i ();
   sbst_tap_dev sbst_tap_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .jtag(sbst_jtag_if_i),
      .pin_in_i(pin_in_i), .pin_test_o(pin_test_o), .pin_val_o(pin_val_o),
      .q_float_o(q_float_o));
   sbst_tap_host sbst_tap_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .jtag(sbst_jtag_if_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .len_i(len_i), .data_i(data_i),
      .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
   sbst_tap_monitor sbst_tap_monitor_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .tck(sbst_jtag_if_i.tck), .tms(sbst_jtag_if_i.tms), .tdi(sbst_jtag_if_i.tdi),
      .tdo_drv(sbst_jtag_if_i.tdo_drv), .tdo_oe(sbst_jtag_if_i.tdo_oe),
      .tdo(sbst_jtag_if_i.tdo));

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Bits seen on the data out wire, first bit ends in bit 0
   always @(posedge sbst_jtag_if_i.tck)
      if (sbst_jtag_if_i.tdo_oe === 1'b1)
         wire_bits = {sbst_jtag_if_i.tdo, wire_bits[31:1]};

   // Whole run is about 7000 clocks, so this only trips on a hang
   always @(posedge clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 40000)
      begin
         err_count = err_count + 1;
         tally_and_finish;
      end
   end

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Reference behaviour of instruction decode and data registers
   task automatic model(input logic [1:0] c, input integer n, input logic [31:0] d);
      if (c == SBST_CMD_IR)
      begin
         exp_q.push_back(SBST_IR_CAPTURE);
         m_ir = d[2:0];
      end
      else if (c == SBST_CMD_DR)
      begin
         if (m_ir == SBST_IR_IDCODE)
            exp_q.push_back(SBST_ID_CODE);
         else if (m_ir == SBST_IR_EXTEST || m_ir == SBST_IR_SAMPLE || m_ir == SBST_IR_SAMPLEZ)
         begin
            exp_q.push_back(pin_in_i);
            m_pv = d[15:0];
         end
         else
            exp_q.push_back((d << 1) & ((64'h1 << n) - 1));
      end
      else
      begin
         m_ir = SBST_IR_IDCODE;
         m_pv = m_pv | 32'h8000;
      end
   endtask : model

   task automatic run(input logic [1:0] c, input integer n, input logic [31:0] d);
      integer k;
      logic fl;
      @(negedge clk_i);
      if (c == SBST_CMD_DR)
         pin_in_i = $random(seed);
      cmd_valid_i = 1'b1;
      cmd_i = c;
      len_i = n[5:0];
      data_i = d;
      model(c, n, d);
      @(posedge clk_i);
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      check(cmd_ready_o, 0);
      k = 0;
      while (rsp_valid_o !== 1'b1 && k < 2000)
      begin
         @(posedge clk_i);
         #1;
         k = k + 1;
      end
      check(k < 2000, 1);
      check(cmd_ready_o, 1);
      if (c != SBST_CMD_RST)
         check(rsp_data_o, exp_q.pop_front());
      fl = m_ir == SBST_IR_SAMPLEZ || (m_ir == SBST_IR_EXTEST && !m_pv[15]);
      check(pin_test_o, m_ir == SBST_IR_EXTEST);
      check(q_float_o, fl);
      check(pin_val_o, m_pv);
   endtask : run

   initial
   begin
      seed = 67520;
      err_count = 0;
      checks = 0;
      cycles = 0;
      nrst_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_i = 2'h0;
      len_i = 6'h00;
      data_i = 32'h0000_0000;
      pin_in_i = 16'h0000;
      wire_bits = 32'h0000_0000;
      m_ir = SBST_IR_IDCODE;
      m_pv = 16'h8000;
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      check(sbst_jtag_if_i.tdo_oe, 0);
      check(pin_val_o, 16'h8000);
      // Port wakes in reset and scans start from idle, so step to idle first
      run(SBST_CMD_RST, 1, 0);
      run(SBST_CMD_DR, 32, $random(seed));
      check(wire_bits, SBST_ID_CODE);
      // Every code, reserved ones included, then a scan through its register
      for (i = 0; i < 8; i = i + 1)
      begin
         run(SBST_CMD_IR, 3, i);
         run(SBST_CMD_DR, i == 1 ? 32 : (i[0] ? 1 + {$random(seed)} % 31 : 16),
            $random(seed));
      end
      repeat (2) run(SBST_CMD_DR, 1, 1);
      run(SBST_CMD_IR, 3, SBST_IR_EXTEST);
      run(SBST_CMD_DR, 16, 32'h7fff);
      // Five TMS-high rises must preset the float cell and restore the ID
      run(SBST_CMD_RST, 1, 0);
      run(SBST_CMD_DR, 32, 0);
      @(negedge clk_i);
      nrst_i = 1'b0;
      m_ir = SBST_IR_IDCODE;
      m_pv = 16'h8000;
      repeat (3) @(negedge clk_i);
      nrst_i = 1'b1;
      check(sbst_jtag_if_i.tdo_oe, 0);
      run(SBST_CMD_RST, 1, 0);
      run(SBST_CMD_DR, 32, 0);
      tally_and_finish;
   end
endmodule : sram_boundary_scan_tap_tb
